// file: dv/event_log_core_tb.sv
// Self-checking bench for the event-logging recorder core.
`timescale 1ns/1ns
module event_log_core_tb;
    import event_log_pkg::*;
    logic clk = 1'b0, host_clk = 1'b0, nrst = 1'b0, event_n = 1'b1;
    logic tick_sec = 1'b0, tick_min = 1'b0, tick_hour = 1'b0;
    logic host_req, host_busy, host_done, mission_running_out;
    logic [1:0] host_cmd;
    logic [7:0] host_addr, host_wdata, host_rdata, v;
    int mismatches = 0, n_tests = 0, cycles = 0;

    always #4 clk = ~clk;
    // Host clock of 15 ns from uneven half periods at 1 ns precision.
    always
    begin
        #7 host_clk = ~host_clk;
        #8 host_clk = ~host_clk;
    end

    event_log_core i_event_log_core (.clk(clk), .nrst(nrst),
        .host_clk(host_clk), .event_n(event_n), .tick_sec(tick_sec),
        .tick_min(tick_min), .tick_hour(tick_hour),
        .time_now(64'h8877665544332211), .host_req(host_req),
        .host_cmd(host_cmd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_busy(host_busy),
        .host_done(host_done), .host_rdata(host_rdata),
        .mission_running_out(mission_running_out));
    host_port_model i_host_port_model (.host_clk(host_clk),
        .host_req(host_req), .host_cmd(host_cmd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_busy(host_busy),
        .host_done(host_done), .host_rdata(host_rdata));

    // Verdict and end of run.
    task automatic finish_test();
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic check(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, d);
        i_host_port_model.wr_reg(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, e);
        i_host_port_model.rd_reg(a, v);
        check($sformatf("reg %h", a), v, e);
    endtask : rd

    task automatic lrd(input logic [15:0] a, input logic [7:0] e);
        i_host_port_model.log_rd(a, v);
        check($sformatf("log %h", a), v, e);
    endtask : lrd

    // Ticks (seconds and minutes together), then a low pulse on the pin.
    task automatic ev(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tick_sec <= 1'b1;
            tick_min <= 1'b1;
            @(posedge clk);
            tick_sec <= 1'b0;
            tick_min <= 1'b0;
        end
        repeat (4) @(posedge clk);
        event_n <= 1'b0;
        repeat (10) @(posedge clk);
        event_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask : ev

    task automatic wipe();
        wr(A_CTRL, 8'h40);
        wr(A_STAT, 8'h10);
        repeat (1100) @(posedge clk);
    endtask : wipe

    // Hang guard over the whole run.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (10) @(posedge clk);
        wipe();
        rd(A_STAT, 8'h40);
        wr(A_CTRL, 8'h00);
        wr(A_STAT, 8'h20);
        ev(2);
        rd(A_STAT, 8'h40);
        wr(A_CTRL, 8'h02);
        wr(A_STAT, 8'h20);
        check("run", {7'h00, mission_running_out}, 8'h01);
        rd(A_CTRL, 8'h82);
        ev(3);
        ev(5);
        ev(7);
        wr(A_STAT, 8'h00);
        check("stop", {7'h00, mission_running_out}, 8'h00);
        rd(A_CTRL, 8'h02);
        rd(A_EVC_LO, 8'h04);
        rd(A_PTR_LO, 8'h06);
        rd(A_STAMP_FIRST, 8'h11);
        rd(A_ROLL_LO, 8'h00);
        lrd(16'h0000, 8'h03);
        lrd(16'h0001, 8'h00);
        lrd(16'h0002, 8'h05);
        lrd(16'h0004, 8'h07);
        wr(A_PORT_DATA, 8'hFF);
        lrd(16'h0000, 8'h03);
        lrd(16'h0800, 8'h00);
        wipe();
        rd(A_EVC_LO, 8'h00);
        wr(A_CTRL, 8'h02);
        wr(A_CTRL, 8'h82);
        rd(A_CTRL, 8'h82);
        ev(1);
        check("armed", {7'h00, mission_running_out}, 8'h01);
        repeat (1030) ev(1);
        wr(A_CTRL, 8'h02);
        rd(A_EVC_LO, 8'h07);
        rd(A_EVC_MID, 8'h04);
        rd(A_PTR_LO, 8'h00);
        rd(A_PTR_HI, 8'h00);
        rd(A_STAT, 8'h00);
        lrd(16'h07FE, 8'h01);
        // Wrap mission: both edges, minute steps, 1024 fills then a wrap.
        wipe();
        wr(A_CTRL, 8'h1E);
        wr(A_STAT, 8'h20);
        repeat (1024)
        begin
            event_n <= ~event_n;
            repeat (4) @(posedge clk);
        end
        repeat (2)
        begin
            @(posedge clk);
            tick_sec <= 1'b1;
            @(posedge clk);
            tick_sec <= 1'b0;
        end
        @(posedge clk);
        tick_min <= 1'b1;
        @(posedge clk);
        tick_min <= 1'b0;
        event_n <= ~event_n;
        repeat (10) @(posedge clk);
        wr(A_STAT, 8'h00);
        rd(A_STAT, 8'h04);
        rd(A_ROLL_LO, 8'h01);
        rd(A_EVC_LO, 8'h02);
        rd(A_EVC_MID, 8'h04);
        rd(A_PTR_LO, 8'h02);
        lrd(16'h0000, 8'h01);
        finish_test();
    end
endmodule : event_log_core_tb

// file: dv/host_port_model.sv
// Host-side model that reaches the recorder's registers and log port.
`timescale 1ns/1ns
module host_port_model
(
    input wire logic host_clk,
    output logic host_req,
    output logic [1:0] host_cmd,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic host_busy,
    input wire logic host_done,
    input wire logic [7:0] host_rdata
);
    initial
    begin
        host_req = 1'b0;
        host_cmd = 2'h3;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end

    // One request pulse, then a bounded wait for the answer pulse.
    task automatic xfer(input logic [1:0] c, input logic [7:0] d,
                        output logic [7:0] r);
        int k;
        logic seen;
        r = 8'hXX;
        seen = 1'b0;
        @(posedge host_clk);
        while (host_busy !== 1'b0)
            @(posedge host_clk);
        host_req <= 1'b1;
        host_cmd <= c;
        host_addr <= d;
        host_wdata <= d;
        @(posedge host_clk);
        host_req <= 1'b0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge host_clk);
            if (host_done === 1'b1)
            begin
                r = host_rdata;
                seen = 1'b1;
                break;
            end
        end
        // A lost answer counts as a mismatch in the bench.
        if (!seen)
            event_log_core_tb.mismatches++;
    endtask : xfer

    // Register write and read through the pointer.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(2'h0, a, r);
        xfer(2'h1, d, r);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] r);
        xfer(2'h0, a, r);
        xfer(2'h2, 8'h00, r);
    endtask : rd_reg

    // Log byte fetch: low address at 41h, pointer moves on to 42h.
    task automatic log_rd(input logic [15:0] a, output logic [7:0] r);
        xfer(2'h0, 8'h41, r);
        xfer(2'h1, a[7:0], r);
        xfer(2'h1, a[15:8], r);
        rd_reg(8'h43, r);
    endtask : log_rd
endmodule : host_port_model

// file: rtl/event_log_core.sv
// Event-logging mission recorder core with a host register port.
`timescale 1ns/1ns
module event_log_core
    import event_log_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic host_clk,
    input wire logic event_n,
    input wire logic tick_sec,
    input wire logic tick_min,
    input wire logic tick_hour,
    input wire logic [STAMP_W-1:0] time_now,
    input wire logic host_req,
    input wire logic [1:0] host_cmd,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic host_busy,
    output logic host_done,
    output logic [7:0] host_rdata,
    output logic mission_running_out
);
    // ------------------------------------------------------------------
    // Reset synchronisers
    // ------------------------------------------------------------------
    logic rst_s1_reg, rst_n_reg, hrst_s1_reg, hrst_n_reg;

    // Reset is asserted at once and released through two flops per domain.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst) begin rst_s1_reg <= 1'b0; rst_n_reg <= 1'b0; end
        else begin rst_s1_reg <= 1'b1; rst_n_reg <= rst_s1_reg; end
    end

    // The host-side copy is released on the host clock.
    always_ff @(posedge host_clk or negedge nrst)
    begin
        if (!nrst) begin hrst_s1_reg <= 1'b0; hrst_n_reg <= 1'b0; end
        else begin hrst_s1_reg <= 1'b1; hrst_n_reg <= hrst_s1_reg; end
    end

    // ------------------------------------------------------------------
    // Host domain: request toggle and answer capture
    // ------------------------------------------------------------------
    logic hreq_tgl_reg, hbusy_reg, hdone_reg;
    logic [1:0] hcmd_reg;
    logic [7:0] haddr_reg, hwdata_reg, hrdata_reg;
    logic hack_s1_reg, hack_s2_reg, hack_s3_reg;
    logic cack_tgl_reg;
    logic [7:0] crdata_reg;
    wire logic hack_seen = hack_s2_reg ^ hack_s3_reg;

    // Command fields stay frozen while busy, so the core may read them.
    always_ff @(posedge host_clk or negedge hrst_n_reg)
    begin
        if (!hrst_n_reg)
        begin
            hreq_tgl_reg <= 1'b0;
            hbusy_reg <= 1'b0;
            hdone_reg <= 1'b0;
            hcmd_reg <= 2'h0;
            haddr_reg <= BYTE_ZERO;
            hwdata_reg <= BYTE_ZERO;
            hrdata_reg <= BYTE_ZERO;
            hack_s1_reg <= 1'b0;
            hack_s2_reg <= 1'b0;
            hack_s3_reg <= 1'b0;
        end
        else
        begin
            hack_s1_reg <= cack_tgl_reg;
            hack_s2_reg <= hack_s1_reg;
            hack_s3_reg <= hack_s2_reg;
            hdone_reg <= hack_seen;
            if (hack_seen)
            begin
                hbusy_reg <= 1'b0;
                hrdata_reg <= crdata_reg;
            end
            else if (host_req && !hbusy_reg)
            begin
                hbusy_reg <= 1'b1;
                hreq_tgl_reg <= ~hreq_tgl_reg;
                hcmd_reg <= host_cmd;
                haddr_reg <= host_addr;
                hwdata_reg <= host_wdata;
            end
        end
    end

    assign host_busy = hbusy_reg;
    assign host_done = hdone_reg;
    assign host_rdata = hrdata_reg;

    // ------------------------------------------------------------------
    // Core domain: synchronisers and command decode
    // ------------------------------------------------------------------
    logic creq_s1_reg, creq_s2_reg, creq_s3_reg;
    logic ev_s1_reg, ev_s2_reg, ev_s3_reg;
    logic [7:0] ptr_reg, ctrl_reg;
    logic [15:0] port_addr_reg;
    mission_t state_reg;
    logic wiped_reg, wrap_flag_reg, full_reg, wiping_reg;
    logic [WORD_AW-1:0] wipe_idx_reg;
    logic [STAMP_W-1:0] stamp_reg;
    logic [ETC_W-1:0] roll_reg, etc_reg;
    logic [EVC_W-1:0] evc_reg;
    logic [LOG_AW-1:0] wptr_reg;
    logic [ETC_W-1:0] log_mem [LOG_WORDS];

    // Requests and the event pin each pass two flops first.
    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            creq_s1_reg <= 1'b0;
            creq_s2_reg <= 1'b0;
            creq_s3_reg <= 1'b0;
            ev_s1_reg <= 1'b1;
            ev_s2_reg <= 1'b1;
            ev_s3_reg <= 1'b1;
        end
        else
        begin
            creq_s1_reg <= hreq_tgl_reg;
            creq_s2_reg <= creq_s1_reg;
            creq_s3_reg <= creq_s2_reg;
            ev_s1_reg <= event_n;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
        end
    end

    // A trigger setting is legal only when some edge is selected.
    function automatic logic trig_ok(input logic [7:0] c);
        return c[CTRL_TRIG_LO] | c[CTRL_TRIG_HI];
    endfunction : trig_ok

    // Request decode; fields are stable since the toggle was sent.
    wire logic req_edge = creq_s2_reg ^ creq_s3_reg;
    wire logic wr_now = req_edge && (hcmd_reg == CMD_WRITE);
    wire logic rd_now = req_edge && (hcmd_reg == CMD_READ);
    wire logic setp_now = req_edge && (hcmd_reg == CMD_SET_PTR);
    wire logic wr_ctrl = wr_now && (ptr_reg == A_CTRL);
    wire logic wr_stat = wr_now && (ptr_reg == A_STAT);
    wire logic wr_plo = wr_now && (ptr_reg == A_PORT_LO);
    wire logic wr_phi = wr_now && (ptr_reg == A_PORT_HI);
    wire logic running = (state_reg == MS_RUN);
    wire logic arm_accept = hwdata_reg[CTRL_ARM] && wiped_reg
                            && trig_ok(hwdata_reg);
    wire logic ctrl_same = wr_ctrl && (hwdata_reg == ctrl_reg);
    wire logic run_write = wr_stat && hwdata_reg[STAT_RUN];
    wire logic start_now = run_write && !running && wiped_reg
                           && trig_ok(ctrl_reg);
    wire logic stop_now = running && wr_now && !wr_plo && !wr_phi
                          && !ctrl_same && !run_write;
    wire logic wipe_go = wr_stat && hwdata_reg[STAT_CLR_MEM]
                         && ctrl_reg[CTRL_CLR_EN] && !running;

    // Edge qualification on the synchronised pin.
    wire logic ev_rise = ev_s2_reg && !ev_s3_reg;
    wire logic ev_fall = !ev_s2_reg && ev_s3_reg;
    wire logic hit = (ev_fall && ctrl_reg[CTRL_TRIG_LO])
                     || (ev_rise && ctrl_reg[CTRL_TRIG_HI]);
    wire logic first_hit = (state_reg == MS_ARMED) && hit && wiped_reg;
    wire logic run_hit = running && hit && !stop_now;
    wire logic log_write = run_hit
                           && (!full_reg || ctrl_reg[CTRL_WRAP]);
    wire logic wrap_now = log_write && full_reg;
    wire logic [1:0] res_sel = ctrl_reg[CTRL_RES_HI:CTRL_RES_LO];
    wire logic etc_tick = (res_sel == RES_SEC) ? tick_sec :
                          (res_sel == RES_MIN) ? tick_min : tick_hour;

    // ------------------------------------------------------------------
    // Register pointer, log port address and control register
    // ------------------------------------------------------------------
    // The pointer steps after each access, so 41h is followed by 42h.
    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ptr_reg <= BYTE_ZERO;
            port_addr_reg <= 16'h0000;
        end
        else
        begin
            if (setp_now)
                ptr_reg <= hwdata_reg;
            else if (wr_now || rd_now)
                ptr_reg <= ptr_reg + 8'h01;
            if (wr_plo)
                port_addr_reg[7:0] <= hwdata_reg;
            if (wr_phi)
                port_addr_reg[15:8] <= hwdata_reg;
        end
    end

    // Control writes store all bits, arm only when accepted.
    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ctrl_reg <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl_reg <= {arm_accept, hwdata_reg[6:0]};
        else
        begin
            if (start_now)
                ctrl_reg[CTRL_ARM] <= 1'b1;
            else if (stop_now)
                ctrl_reg[CTRL_ARM] <= 1'b0;
            if (wr_now)
                ctrl_reg[CTRL_CLR_EN] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Mission sequencing and counters
    // ------------------------------------------------------------------
    // Starts, stops, logging steps, wrap handling and the wipe sweep.
    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= MS_IDLE;
            wiped_reg <= 1'b0;
            wrap_flag_reg <= 1'b0;
            full_reg <= 1'b0;
            wiping_reg <= 1'b0;
            wipe_idx_reg <= '0;
            stamp_reg <= '0;
            roll_reg <= '0;
            etc_reg <= '0;
            evc_reg <= '0;
            wptr_reg <= '0;
        end
        else if (wipe_go)
        begin
            wiping_reg <= 1'b1;
            wipe_idx_reg <= '0;
            wiped_reg <= 1'b0;
            wrap_flag_reg <= 1'b0;
            full_reg <= 1'b0;
            stamp_reg <= '0;
            roll_reg <= '0;
            etc_reg <= '0;
            evc_reg <= '0;
            wptr_reg <= '0;
        end
        else
        begin
            if (wiping_reg)
            begin
                wipe_idx_reg <= wipe_idx_reg + 1'b1;
                if (&wipe_idx_reg)
                begin
                    wiping_reg <= 1'b0;
                    wiped_reg <= 1'b1;
                end
            end
            unique case (state_reg)
                MS_IDLE:
                begin
                    if (start_now)
                        state_reg <= MS_RUN;
                    else if (wr_ctrl && arm_accept)
                        state_reg <= MS_ARMED;
                end
                MS_ARMED:
                begin
                    if (start_now || first_hit)
                        state_reg <= MS_RUN;
                    else if (wr_ctrl && !arm_accept)
                        state_reg <= MS_IDLE;
                end
                MS_RUN:
                begin
                    if (stop_now)
                        state_reg <= MS_IDLE;
                end
                default:
                    state_reg <= MS_IDLE;
            endcase
            if (start_now || first_hit)
            begin
                wiped_reg <= 1'b0;
                stamp_reg <= time_now;
                roll_reg <= '0;
                evc_reg <= evc_reg + 1'b1;
                etc_reg <= '0;
            end
            else if (run_hit)
            begin
                evc_reg <= evc_reg + 1'b1;
                etc_reg <= '0;
            end
            else if (running && etc_tick)
                etc_reg <= etc_reg + 1'b1;
            if (log_write)
            begin
                wptr_reg <= wptr_reg + PTR_STEP;
                full_reg <= (wptr_reg == LAST_WORD_PTR);
            end
            if (wrap_now)
            begin
                stamp_reg <= time_now;
                roll_reg <= etc_reg;
                wrap_flag_reg <= 1'b1;
            end
        end
    end

    // The log is written only by the mission logic or the wipe sweep.
    always_ff @(posedge clk)
    begin
        if (wiping_reg)
            log_mem[wipe_idx_reg] <= '0;
        else if (log_write)
            log_mem[wptr_reg[LOG_AW-1:1]] <= etc_reg;
    end

    // ------------------------------------------------------------------
    // Read path and answer toggle
    // ------------------------------------------------------------------
    wire logic [ETC_W-1:0] port_word = log_mem[port_addr_reg[LOG_AW-1:1]];
    wire logic port_in_log = (port_addr_reg[15:LOG_AW] == '0);
    wire logic [7:0] port_byte = !port_in_log ? BYTE_ZERO :
        port_addr_reg[0] ? port_word[15:8] : port_word[7:0];
    wire logic hidden = running && (ptr_reg >= A_STAMP_FIRST);
    wire logic [7:0] stat_byte = {1'b0, wiped_reg, running, wiping_reg,
                                  1'b0, wrap_flag_reg, 2'b00};
    logic [7:0] read_value;

    // Main register read multiplexer; gaps and hidden space read zero.
    always_comb
    begin
        read_value = BYTE_ZERO;
        if (!hidden)
        begin
            if (ptr_reg >= A_STAMP_FIRST && ptr_reg <= A_STAMP_LAST)
                read_value = stamp_reg[8*(ptr_reg[2:0]) +: 8];
            else
            begin
                unique case (ptr_reg)
                    A_CTRL: read_value = ctrl_reg;
                    A_STAT: read_value = stat_byte;
                    A_ROLL_LO: read_value = roll_reg[7:0];
                    A_ROLL_HI: read_value = roll_reg[15:8];
                    A_EVC_LO: read_value = evc_reg[7:0];
                    A_EVC_MID: read_value = evc_reg[15:8];
                    A_EVC_HI: read_value = evc_reg[23:16];
                    A_ETC_LO: read_value = etc_reg[7:0];
                    A_ETC_HI: read_value = etc_reg[15:8];
                    A_PTR_LO: read_value = wptr_reg[7:0];
                    A_PTR_HI: read_value = {5'h00, wptr_reg[10:8]};
                    A_PORT_LO: read_value = port_addr_reg[7:0];
                    A_PORT_HI: read_value = port_addr_reg[15:8];
                    A_PORT_DATA: read_value = port_byte;
                    default: read_value = BYTE_ZERO;
                endcase
            end
        end
    end

    // Every request is answered by a toggle once its result is held.
    always_ff @(posedge clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            crdata_reg <= BYTE_ZERO;
            cack_tgl_reg <= 1'b0;
            mission_running_out <= 1'b0;
        end
        else
        begin
            mission_running_out <= running;
            if (req_edge)
            begin
                cack_tgl_reg <= ~cack_tgl_reg;
                if (rd_now)
                    crdata_reg <= read_value;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // All checks sample on the core clock and sleep during reset.
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n_reg);

    AST_TRIG_ZERO: assert property (
        (!trig_ok(ctrl_reg) && state_reg != MS_RUN) |=> state_reg != MS_RUN)
        else $error("Mission started with no trigger edge selected.");
    AST_PTR_STEP: assert property (
        (log_write && !wipe_go) |=> wptr_reg == $past(wptr_reg) + PTR_STEP)
        else $error("Log pointer did not advance by one entry.");
    AST_EVC_COUNT: assert property (
        (run_hit && !wipe_go) |=> evc_reg == $past(evc_reg) + 1'b1)
        else $error("Event counter missed an event.");
    AST_WRAP_STICKY: assert property (
        (wrap_flag_reg && !wipe_go) |=> wrap_flag_reg)
        else $error("Wrap flag dropped without a wipe.");
    AST_ARM_GATE: assert property (
        (wr_ctrl && !wiped_reg) |=> !ctrl_reg[CTRL_ARM])
        else $error("Arm accepted while log not wiped.");
    AST_RUN_GATE: assert property (
        $rose(running) |-> $past(wiped_reg))
        else $error("Mission started while log not wiped.");
    AST_START: assert property (
        start_now |=> running && ctrl_reg[CTRL_ARM] && roll_reg == '0
        && evc_reg == $past(evc_reg) + 1'b1)
        else $error("Immediate start did not set up the mission.");
    AST_STOP_ARM: assert property (
        $fell(running) |-> !ctrl_reg[CTRL_ARM])
        else $error("Arm bit left set after stop.");
    AST_WRITE_STOP: assert property (
        stop_now |=> state_reg == MS_IDLE ##1 !mission_running_out)
        else $error("Host write did not stop the mission.");
    AST_ETC_TICK: assert property (
        (running && etc_tick && !hit && !wipe_go)
        |=> etc_reg == $past(etc_reg) + 1'b1)
        else $error("Interval counter missed a tick.");
endmodule : event_log_core

// file: rtl/event_log_pkg.sv
// Shared constants and types for the event-logging mission recorder core.
package event_log_pkg;
    // Log geometry.
    localparam int LOG_BYTES = 2048;
    localparam int LOG_WORDS = 1024;
    localparam int LOG_AW = 11;
    localparam int WORD_AW = 10;
    localparam int EVC_W = 24;
    localparam int ETC_W = 16;
    localparam int STAMP_W = 64;
    // Main register map.
    localparam logic [7:0] A_CTRL = 8'h0E;
    localparam logic [7:0] A_STAT = 8'h0F;
    localparam logic [7:0] A_STAMP_FIRST = 8'h30;
    localparam logic [7:0] A_STAMP_LAST = 8'h37;
    localparam logic [7:0] A_ROLL_LO = 8'h38;
    localparam logic [7:0] A_ROLL_HI = 8'h39;
    localparam logic [7:0] A_EVC_LO = 8'h3A;
    localparam logic [7:0] A_EVC_MID = 8'h3B;
    localparam logic [7:0] A_EVC_HI = 8'h3C;
    localparam logic [7:0] A_ETC_LO = 8'h3D;
    localparam logic [7:0] A_ETC_HI = 8'h3E;
    localparam logic [7:0] A_PTR_LO = 8'h3F;
    localparam logic [7:0] A_PTR_HI = 8'h40;
    localparam logic [7:0] A_PORT_LO = 8'h41;
    localparam logic [7:0] A_PORT_HI = 8'h42;
    localparam logic [7:0] A_PORT_DATA = 8'h43;
    // Control register fields.
    localparam int CTRL_ARM = 7;
    localparam int CTRL_CLR_EN = 6;
    localparam int CTRL_RES_HI = 5;
    localparam int CTRL_RES_LO = 4;
    localparam int CTRL_WRAP = 3;
    localparam int CTRL_TRIG_HI = 2;
    localparam int CTRL_TRIG_LO = 1;
    // Status register fields.
    localparam int STAT_WIPED = 6;
    localparam int STAT_RUN = 5;
    localparam int STAT_CLR_MEM = 4;
    localparam int STAT_WRAP = 2;
    // Resolution select codes.
    localparam logic [1:0] RES_SEC = 2'h0;
    localparam logic [1:0] RES_MIN = 2'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [10:0] LAST_WORD_PTR = 11'h7FE;
    localparam logic [10:0] PTR_STEP = 11'h002;
    // Host command codes.
    typedef enum logic [1:0] {CMD_SET_PTR, CMD_WRITE, CMD_READ} host_cmd_t;
    // Mission states.
    typedef enum logic [1:0] {MS_IDLE, MS_ARMED, MS_RUN} mission_t;
endpackage : event_log_pkg
